// File: logic/quad_uart_host_bus_port.sv
`timescale 1ns/1ns
//
// Function
// R1: Mode pin high selects strobe style; read strobe is active low.
// R2: Strobe style: read strobe fall reads addressed register onto data bus.
// R3: Strobe style: write strobe rise stores the bus byte into addressed register.
// R4: Mode pin low: write strobe input is direction, high read, low write.
// R5: Read/write-line style ignores the read strobe input.
// R6: Strobe style: four active-low selects each enable their own channel.
// R7: Read/write-line style: channel A select is the single device select.
// R8: Read/write-line style: channel B select is channel address bit 3.
// R9: Read/write-line style: channel C select is channel address bit 4.
// R10: Read/write-line style ignores the channel D select input.
// R11: Strobe style: channel A interrupt driven when modem control bit 3 set.
// R12: Read/write-line style: interrupt pin is active-low open drain.
// R13: Three address inputs choose one of eight registers in the channel.
// R14: Eight-bit data bus driven only during reads, sampled during writes.
// R15: Extra address bits form a two-bit channel index, zero is channel A.
module quad_uart_host_bus_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bus style select
  input wire logic bus_style_sel,
  // Host bus
  input wire logic [host_port_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [host_port_pkg::DATA_W-1:0] data_in,
  output logic [host_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_c_select_n,
  input wire logic chan_d_select_n,
  // Interrupt source and pin
  input wire logic [host_port_pkg::NUM_CHAN-1:0] chan_irq,
  output logic chan_a_irq_out,
  output logic chan_a_irq_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd_active;
    logic wr_active;
    logic rw_active;
    logic rw_is_read;
    logic [host_port_pkg::MEM_ADDR_W-1:0] wr_addr;
    logic [host_port_pkg::MEM_ADDR_W-1:0] rd_addr;
    logic rd_valid;
    // Marks the cycle in which the memory's registered read data belong to rd_addr.
    logic rd_pend;
    logic [host_port_pkg::DATA_W-1:0] data_out;
    logic data_oe;
    logic [host_port_pkg::NUM_CHAN-1:0] irq_en;
    logic irq_out;
    logic irq_oe;
  } port_state_s;

  port_state_s st_q;
  port_state_s st_d;

  logic sel_valid;
  logic [host_port_pkg::CHAN_W-1:0] sel_chan;
  logic rd_req;
  logic wr_req;
  logic mem_wr_en;
  logic [host_port_pkg::DATA_W-1:0] mem_rd_data;

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  always_comb begin
    sel_valid = 1'b0;
    sel_chan = host_port_pkg::CHAN_A;
    if (bus_style_sel == host_port_pkg::STYLE_STROBE) begin
      // Exactly one select is expected low; the lowest channel wins otherwise.
      if (!chan_a_select_n) begin // see R6
        sel_valid = 1'b1;
        sel_chan = host_port_pkg::CHAN_A;
      end else if (!chan_b_select_n) begin
        sel_valid = 1'b1;
        sel_chan = host_port_pkg::CHAN_B;
      end else if (!chan_c_select_n) begin
        sel_valid = 1'b1;
        sel_chan = host_port_pkg::CHAN_C;
      end else if (!chan_d_select_n) begin
        sel_valid = 1'b1;
        sel_chan = host_port_pkg::CHAN_D;
      end
    end else begin
      sel_valid = !chan_a_select_n; // see R7
      sel_chan = {chan_c_select_n, chan_b_select_n}; // see R8 see R9 see R10 see R15
    end
  end

  // ----------------------------------------------------------------
  // Transfer requests
  // ----------------------------------------------------------------
  always_comb begin
    if (bus_style_sel == host_port_pkg::STYLE_STROBE) begin
      rd_req = sel_valid && !read_strobe_n; // see R1 see R2
      wr_req = sel_valid && !write_strobe_n; // see R3
    end else begin
      // Read strobe plays no part in this style.
      rd_req = sel_valid && (write_strobe_n == host_port_pkg::RW_READ); // see R4 see R5
      wr_req = sel_valid && (write_strobe_n != host_port_pkg::RW_READ); // see R4
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    mem_wr_en = 1'b0;
    st_d.rd_valid = 1'b0;
    if (bus_style_sel == host_port_pkg::STYLE_STROBE) begin
      st_d.rw_active = 1'b0;
      // Read starts on the falling strobe edge.
      if (rd_req && !st_q.rd_active) begin // see R2
        st_d.rd_addr = {sel_chan, reg_addr}; // see R13
        st_d.rd_valid = 1'b1;
      end
      st_d.rd_active = rd_req;
      // Write latches address on the falling edge and data on the rising edge.
      if (wr_req && !st_q.wr_active) begin // see R3
        st_d.wr_addr = {sel_chan, reg_addr};
      end
      if (!wr_req && st_q.wr_active) begin // see R3
        mem_wr_en = 1'b1;
      end
      st_d.wr_active = wr_req;
    end else begin
      st_d.rd_active = 1'b0;
      st_d.wr_active = 1'b0;
      if (sel_valid && !st_q.rw_active) begin
        st_d.rw_is_read = rd_req;
        st_d.rd_addr = {sel_chan, reg_addr};
        st_d.wr_addr = {sel_chan, reg_addr};
        st_d.rd_valid = rd_req;
      end
      // A write completes when the device select is released.
      if (!sel_valid && st_q.rw_active && !st_q.rw_is_read) begin
        mem_wr_en = 1'b1;
      end
      st_d.rw_active = sel_valid;
    end
    // The memory registers its read data, so the byte for a new address is one cycle late.
    st_d.rd_pend = st_q.rd_valid;
    if (st_q.rd_pend) begin // see R2
      st_d.data_out = mem_rd_data;
    end
    st_d.data_oe = rd_req; // see R14
    if (mem_wr_en && st_q.wr_addr[host_port_pkg::ADDR_W-1:0] == host_port_pkg::MCR_INDEX) begin
      st_d.irq_en[st_q.wr_addr[host_port_pkg::MEM_ADDR_W-1:host_port_pkg::ADDR_W]] =
        data_in[host_port_pkg::MCR_IRQ_EN_BIT]; // see R11
    end
    if (bus_style_sel == host_port_pkg::STYLE_STROBE) begin
      st_d.irq_out = chan_irq[host_port_pkg::CHAN_A];
      st_d.irq_oe = st_q.irq_en[host_port_pkg::CHAN_A]; // see R11
    end else begin
      // Pull low only while any channel requests service.
      st_d.irq_out = 1'b0;
      st_d.irq_oe = |chan_irq; // see R12
    end
    if (!resetn) begin
      st_d = '0;
      st_d.data_out = host_port_pkg::DATA_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  chan_reg_mem u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_wr_en),
    .wr_addr(st_q.wr_addr),
    .wr_data(data_in),
    .rd_addr(st_q.rd_addr),
    .rd_data(mem_rd_data)
  );

  assign data_out = st_q.data_out;
  assign data_oe = st_q.data_oe;
  assign chan_a_irq_out = st_q.irq_out;
  assign chan_a_irq_oe = st_q.irq_oe;

endmodule

// File: include/host_port_pkg.sv
package host_port_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int NUM_CHAN = 4;
  localparam int CHAN_W = 2;
  localparam int REGS_PER_CHAN = 8;
  localparam int MEM_ADDR_W = CHAN_W + ADDR_W;
  localparam int MEM_DEPTH = NUM_CHAN * REGS_PER_CHAN;

  // Modem-control bit that enables the channel A interrupt driver in strobe style.
  localparam int MCR_IRQ_EN_BIT = 3;
  // Register index of the modem-control register within each channel.
  localparam logic [ADDR_W-1:0] MCR_INDEX = 3'h4;

  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_A = 2'h0;
  localparam logic [CHAN_W-1:0] CHAN_B = 2'h1;
  localparam logic [CHAN_W-1:0] CHAN_C = 2'h2;
  localparam logic [CHAN_W-1:0] CHAN_D = 2'h3;

  // Bus style selected by the mode pin.
  localparam logic STYLE_STROBE = 1'b1;
  localparam logic STYLE_RW_LINE = 1'b0;
  localparam logic RW_READ = 1'b1;

endpackage

// File: logic/chan_reg_mem.sv
`timescale 1ns/1ns
module chan_reg_mem (
  // Clock
  input wire logic ref_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [host_port_pkg::MEM_ADDR_W-1:0] wr_addr,
  input wire logic [host_port_pkg::DATA_W-1:0] wr_data,
  // Read port
  input wire logic [host_port_pkg::MEM_ADDR_W-1:0] rd_addr,
  output logic [host_port_pkg::DATA_W-1:0] rd_data
);

  logic [host_port_pkg::DATA_W-1:0] mem [host_port_pkg::MEM_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// File: tb/host_port_props.sv
`timescale 1ns/1ns
module host_port_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Host bus
  input wire logic bus_style_sel,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_c_select_n,
  input wire logic chan_d_select_n,
  // Interrupt
  input wire logic [3:0] chan_irq,
  input wire logic chan_a_irq_out,
  input wire logic chan_a_irq_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_quiet; (bus_style_sel && read_strobe_n)[*4]; endsequence
  sequence s_steady; (bus_style_sel && write_strobe_n)[*3]; endsequence
  a_strobe_read: assert property (bus_style_sel && !chan_a_select_n && !read_strobe_n
    |=> data_oe) else $error("no read drive");
  a_rw_read: assert property (!bus_style_sel && !chan_a_select_n && write_strobe_n
    |=> data_oe) else $error("no rw read drive");
  a_strobe_idle: assert property (bus_style_sel && read_strobe_n |=> !data_oe)
    else $error("stray drive");
  a_rw_write: assert property (!bus_style_sel && !write_strobe_n |=> !data_oe)
    else $error("drive in rw write");
  a_out_hold: assert property (s_quiet |-> $stable(data_out))
    else $error("read data moved");
  a_irq_follow: assert property (resetn && bus_style_sel |=> chan_a_irq_out == $past(chan_irq[0]))
    else $error("irq level");
  a_irq_drain: assert property (resetn && !bus_style_sel |=> !chan_a_irq_out &&
    chan_a_irq_oe == ($past(chan_irq) != 4'h0)) else $error("irq drain");
  a_irq_oe_hold: assert property (s_steady |=> $stable(chan_a_irq_oe))
    else $error("irq enable moved");
endmodule
bind quad_uart_host_bus_port host_port_props props (.*);

// File: tb/host_cpu.sv
`timescale 1ns/1ns
module host_cpu (
  // Clock
  input wire logic ref_clk,
  // Bus towards the device
  output logic bus_style_sel,
  output logic [2:0] reg_addr,
  output logic [7:0] host_data,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] select_n,
  // Read data
  input wire logic [7:0] data_out
);
  initial begin
    bus_style_sel = 1'h1;
    reg_addr = 3'h0;
    host_data = 8'h00;
    read_strobe_n = 1'h1;
    write_strobe_n = 1'h1;
    select_n = 4'hF;
  end
  task automatic access(input logic st, input logic wr, input logic [4:0] loc,
    input logic [7:0] wd, input logic [1:0] nz, output logic [7:0] rd);
    @(posedge ref_clk);
    bus_style_sel <= st;
    reg_addr <= loc[2:0];
    host_data <= wd;
    write_strobe_n <= !wr;
    read_strobe_n <= st ? wr : nz[0];
    select_n <= st ? ~(4'h1 << loc[4:3]) : {nz[1], loc[4:3], 1'h0};
    repeat (4) @(posedge ref_clk);
    #1 rd = data_out;
    // The strobe or device select ends first; address and data stay one cycle more.
    @(posedge ref_clk);
    if (st) begin
      read_strobe_n <= 1'h1;
      write_strobe_n <= 1'h1;
    end else begin
      select_n[0] <= 1'h1;
    end
    @(posedge ref_clk);
    read_strobe_n <= 1'h1;
    write_strobe_n <= 1'h1;
    select_n <= 4'hF;
  endtask
endmodule

// File: tb/quad_uart_host_bus_port_tb.sv
`timescale 1ns/1ns
module quad_uart_host_bus_port_tb;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic [3:0] chan_irq = 4'h0;
  logic bus_style_sel, read_strobe_n, write_strobe_n, data_oe, chan_a_irq_out, chan_a_irq_oe;
  logic chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n;
  logic [2:0] reg_addr;
  logic [7:0] host_data, data_in, data_out, got;
  logic [7:0] shadow [32];
  logic [31:0] seed = 32'h53F7C947;
  logic [31:0] irq_seed = 32'h53F7C947;
  int n_mismatch = 0;
  int checks_done = 0;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] en_val(input logic en);
    return en ? 8'h01 << host_port_pkg::MCR_IRQ_EN_BIT : 8'h00;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    irq_seed <= lfsr(irq_seed);
    chan_irq <= irq_seed[3:0];
  end
  assign data_in = data_oe ? data_out : host_data;
  host_cpu cpu (.*, .select_n({chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n}));
  quad_uart_host_bus_port uut (.*);
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'h1;
    @(posedge ref_clk);
    #1 chk({7'h00, chan_a_irq_oe}, 8'h00, "irq enable at reset");
    for (int i = 0; i < 112; i++) begin
      seed = lfsr(seed);
      if (i < 32) seed[6:0] = {i[4:0], 1'h1, i[0]};
      cpu.access(seed[0], seed[1], seed[6:2], seed[15:8], seed[17:16], got);
      if (seed[1]) shadow[seed[6:2]] = seed[15:8];
      else chk(got, shadow[seed[6:2]], "read data");
    end
    for (int b = 1; b >= 0; b--) begin
      cpu.access(1'h1, 1'h1, {2'h0, host_port_pkg::MCR_INDEX}, en_val(b[0]), 2'h0, got);
      repeat (2) @(posedge ref_clk);
      #1 chk({7'h00, chan_a_irq_oe}, {7'h00, b[0]}, "irq enable");
    end
    cpu.access(1'h0, 1'h0, 5'h1F, 8'hA5, 2'h3, got);
    #1 chk({7'h00, chan_a_irq_out}, 8'h00, "irq pin level");
    close_out;
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
endmodule
